// >>> hdl/stop_mode_wake_control.sv
// Halted-state wake and reset sequencer: weighs wake sources, times recovery,
// records the cause and gates port input capture.
// Assumes the watchdog and CPU run on REF_CLK_I; pins are asynchronous.
`include "wake_ctl_defs.svh"

module stop_mode_wake_control
  import wake_ctl_pkg::*;
#(
  parameter int PINS = 8,
  parameter int WAKE_MIN_CYC = `WAKE_MIN_CYC,
  parameter int RECOVERY_CYC = `RECOVERY_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic HALT_REQ_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic WDT_RESET_MODE_I,
  input wire logic IRQ_GLOBAL_EN_I,
  input wire logic [PINS-1:0] WAKE_EN_I,
  input wire logic [PINS-1:0] PORT_PIN_I,
  input wire logic EXT_RESET_N_I,
  input wire logic DEBUG_PIN_I,
  input wire logic CAUSE_CLEAR_I,
  output logic HALTED_O,
  output logic CPU_CLK_EN_O,
  output logic FETCH_RESUME_O,
  output logic SYS_RESET_O,
  output logic WDT_IRQ_O,
  output logic PORT_CAPTURE_EN_O,
  output logic [PINS-1:0] PORT_INPUT_DATA_O,
  output logic [`CAUSE_W-1:0] RESET_CAUSE_O
);

  localparam int RCV_W = $clog2(RECOVERY_CYC + 1);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  wake_state_e state_ff;
  wake_state_e nxt_state;
  logic [RCV_W-1:0] rcv_cnt_ff;
  logic [RCV_W-1:0] nxt_rcv_cnt;
  logic wdt_int_ff;
  logic irq_ff;
  logic resume_ff;
  logic sysrst_ff;
  logic [PINS-1:0] port_data_ff;
  logic [`CAUSE_W-1:0] cause_ff;
  logic [`CAUSE_W-1:0] cause_set;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic dbg_meta_ff;
  logic dbg_sync_ff;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_change;
  logic [PINS-1:0] pin_short;

  // --------------------------------------------------------------------------
  // Reset and debug pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ext_meta_ff <= 1'b1;
      ext_sync_ff <= 1'b1;
      dbg_meta_ff <= 1'b1;
      dbg_sync_ff <= 1'b1;
    end else begin
      ext_meta_ff <= EXT_RESET_N_I;
      ext_sync_ff <= ext_meta_ff;
      dbg_meta_ff <= DEBUG_PIN_I;
      dbg_sync_ff <= dbg_meta_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Per-pin wake watchers
  // --------------------------------------------------------------------------
  wire halted = (state_ff == ST_HALTED);

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      wake_pin_watch #(
        .MIN_CYC(WAKE_MIN_CYC)
      ) wake_pin_watch_i (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .pin_i(PORT_PIN_I[gi]),
        .watch_i(halted && WAKE_EN_I[gi]),
        .level_o(pin_level[gi]),
        .change_o(pin_change[gi]),
        .short_o(pin_short[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Wake source decode
  // --------------------------------------------------------------------------
  // A system-reset request outranks every wake source
  wire ext_req = halted && !ext_sync_ff;
  wire dbg_req = halted && !dbg_sync_ff;
  wire sys_req = ext_req || dbg_req;
  wire wdt_req = halted && WDT_TIMEOUT_I;
  wire pin_wake = halted && (|pin_change);
  wire pin_short_any = halted && (|pin_short);
  wire wake_req = wdt_req || pin_wake;
  wire in_recover = (state_ff == ST_RECOVER);
  wire rcv_done = in_recover && (rcv_cnt_ff == RCV_W'(RECOVERY_CYC - 1));

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (HALT_REQ_I) begin
          nxt_state = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (sys_req) begin
          nxt_state = ST_SYSRESET;
        end else if (wake_req) begin
          nxt_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (rcv_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_SYSRESET: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  assign nxt_rcv_cnt = in_recover ? rcv_cnt_ff + 1'b1 : '0;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff <= ST_RUN;
      rcv_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      rcv_cnt_ff <= nxt_rcv_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog interrupt, held back until recovery ends
  // --------------------------------------------------------------------------
  wire wdt_int_wake = wdt_req && !sys_req && !WDT_RESET_MODE_I;
  wire irq_fire = rcv_done && wdt_int_ff && IRQ_GLOBAL_EN_I;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wdt_int_ff <= 1'b0;
      irq_ff <= 1'b0;
      resume_ff <= 1'b0;
      sysrst_ff <= 1'b0;
    end else begin
      wdt_int_ff <= wdt_int_wake || (wdt_int_ff && !rcv_done);
      irq_ff <= irq_fire;
      resume_ff <= rcv_done;
      // The reset pulse stands in the single SYSRESET cycle
      sysrst_ff <= halted && sys_req;
    end
  end

  // --------------------------------------------------------------------------
  // Reset cause register, a set wins over a clear
  // --------------------------------------------------------------------------
  always_comb begin
    cause_set = '0;
    cause_set[`CAUSE_HALT_BIT] = rcv_done || wdt_req || pin_short_any;
    cause_set[`CAUSE_WDOG_BIT] = wdt_req;
    cause_set[`CAUSE_EXT_BIT] = ext_req;
    cause_set[`CAUSE_DBG_BIT] = dbg_req;
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cause_ff <= `CAUSE_RESET;
    end else begin
      cause_ff <= (CAUSE_CLEAR_I ? '0 : cause_ff) | cause_set;
    end
  end

  // --------------------------------------------------------------------------
  // Port input data, frozen while halted or recovering
  // --------------------------------------------------------------------------
  wire port_load = (state_ff == ST_RUN) || rcv_done;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      port_data_ff <= '0;
    end else if (port_load) begin
      port_data_ff <= pin_level;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign HALTED_O = halted;
  assign CPU_CLK_EN_O = (state_ff == ST_RUN);
  assign FETCH_RESUME_O = resume_ff;
  assign SYS_RESET_O = sysrst_ff;
  assign WDT_IRQ_O = irq_ff;
  assign PORT_CAPTURE_EN_O = (state_ff == ST_RUN);
  assign PORT_INPUT_DATA_O = port_data_ff;
  assign RESET_CAUSE_O = cause_ff;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // Watchdog wake
  a_halt_flag_done: assert property (rcv_done |=> RESET_CAUSE_O[`CAUSE_HALT_BIT])
    else $error("halt flag not set after recovery");
  a_wdt_reset_wake: assert property (
    wdt_req && WDT_RESET_MODE_I && !sys_req |=> in_recover ##1 !SYS_RESET_O)
    else $error("reset-mode watchdog did not start recovery");
  a_reset_mode_quiet: assert property (
    wdt_req && WDT_RESET_MODE_I && !sys_req |=> !wdt_int_ff)
    else $error("reset-mode watchdog wake armed an interrupt");
  a_wdt_irq_gate: assert property (WDT_IRQ_O |-> $past(IRQ_GLOBAL_EN_I))
    else $error("watchdog interrupt raised with interrupts disabled");
  a_irq_mode: assert property (WDT_IRQ_O |-> $past(wdt_int_ff))
    else $error("watchdog interrupt without an interrupt-mode wake");
  a_irq_after_rcv: assert property (WDT_IRQ_O |-> $past(rcv_done) && FETCH_RESUME_O)
    else $error("watchdog interrupt not aligned to end of recovery");
  a_wdt_flags: assert property (
    wdt_req |=> RESET_CAUSE_O[`CAUSE_WDOG_BIT] && RESET_CAUSE_O[`CAUSE_HALT_BIT])
    else $error("watchdog wake flags not set");
  a_clear_loses: assert property (
    wdt_req && CAUSE_CLEAR_I |=> RESET_CAUSE_O[`CAUSE_WDOG_BIT])
    else $error("cause clear won over a watchdog wake");

  // System reset sources
  a_ext_sysreset: assert property (ext_req |=> state_ff == ST_SYSRESET && SYS_RESET_O)
    else $error("external reset while halted did not reset");
  a_dbg_sysreset: assert property (dbg_req |=> state_ff == ST_SYSRESET && SYS_RESET_O)
    else $error("debug pin low while halted did not reset");
  a_sys_no_recover: assert property (sys_req |=> !in_recover)
    else $error("system reset request started a recovery");
  a_sys_exclusive: assert property (SYS_RESET_O |-> !FETCH_RESUME_O && !WDT_IRQ_O)
    else $error("system reset pulse overlapped a resume");

  // Pin wake and port capture
  a_pin_wake: assert property (pin_wake && !sys_req |=> in_recover)
    else $error("pin change did not start recovery");
  a_short_pulse: assert property (
    pin_short_any && !wake_req && !sys_req |=> halted && RESET_CAUSE_O[`CAUSE_HALT_BIT])
    else $error("short wake pulse handled wrongly");
  a_short_stays: assert property (halted && !sys_req && !wake_req |=> halted)
    else $error("halted state left without a wake source");
  a_port_frozen: assert property (
    (state_ff != ST_RUN) && !rcv_done |=> $stable(PORT_INPUT_DATA_O))
    else $error("port input data changed while halted");
  a_port_capture: assert property (rcv_done |=> PORT_INPUT_DATA_O == $past(pin_level))
    else $error("port input data not captured at end of recovery");

  // Recovery timing
  a_halt_entry: assert property (
    HALT_REQ_I && (state_ff == ST_RUN) |=> HALTED_O && !CPU_CLK_EN_O && !PORT_CAPTURE_EN_O)
    else $error("halt request did not stop clock and capture");
  a_rcv_start: assert property ($rose(in_recover) |-> rcv_cnt_ff == '0 && !CPU_CLK_EN_O)
    else $error("recovery delay did not start from zero");
  a_rcv_length: assert property (
    $fell(in_recover) |-> $past(rcv_cnt_ff) == RCV_W'(RECOVERY_CYC - 1) && CPU_CLK_EN_O)
    else $error("recovery delay length wrong");
  a_clk_held: assert property (in_recover |-> !CPU_CLK_EN_O && !FETCH_RESUME_O)
    else $error("clock or fetch released during recovery delay");
  a_resume_once: assert property (FETCH_RESUME_O |=> !FETCH_RESUME_O)
    else $error("resume pulse longer than one cycle");

  c_wdt_wake: cover property (wdt_req && !sys_req ##1 in_recover);
  c_pin_wake: cover property (pin_wake ##[1:200] FETCH_RESUME_O);
  c_sysreset: cover property (sys_req ##1 SYS_RESET_O);
  c_wdt_irq: cover property (WDT_IRQ_O);
  c_short_pulse: cover property (pin_short_any && !wake_req);

endmodule // stop_mode_wake_control

// >>> hdl/wake_ctl_defs.svh
// Timing counts and reset-cause field layout for the halted-state wake control.
// Assumes a single system clock at the rate given by CLK_PERIOD_NS.
`ifndef WAKE_CTL_DEFS_SVH
`define WAKE_CTL_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 20

// ----------------------------------------------------------------------------
// Timing: least times, rounded up to whole cycles
// ----------------------------------------------------------------------------
`define WAKE_MIN_PULSE_NS 100
`define WAKE_MIN_CYC ((`WAKE_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_DELAY_NS 2000
`define RECOVERY_CYC ((`RECOVERY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Reset cause register layout
// ----------------------------------------------------------------------------
`define CAUSE_W 8
`define CAUSE_RESET 8'h00
`define CAUSE_HALT_BIT 7
`define CAUSE_EXT_BIT 6
`define CAUSE_WDOG_BIT 5
`define CAUSE_DBG_BIT 4

`endif

// >>> hdl/wake_ctl_pkg.sv
// Types shared by the halted-state wake control.
// Assumes nothing of its surroundings.
package wake_ctl_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RUN      = 4'h1,
    ST_HALTED   = 4'h2,
    ST_RECOVER  = 4'h4,
    ST_SYSRESET = 4'h8
  } wake_state_e;

endpackage

// >>> hdl/wake_pin_watch.sv
// One port pin watched as a wake source: synchroniser, change detect, width qualifier.
// Assumes the pin is asynchronous to clk_i; watch_i comes from the clk_i domain.
module wake_pin_watch #(
  parameter int MIN_CYC = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic watch_i,
  output logic level_o,
  output logic change_o,
  output logic short_o
);

  localparam int CNT_W = $clog2(MIN_CYC + 1);

  logic meta_ff;
  logic sync_ff;
  logic ref_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // --------------------------------------------------------------------------
  // Synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Change qualifier
  // --------------------------------------------------------------------------
  wire differs = watch_i && (sync_ff != ref_ff);
  wire reached = (cnt_ff == CNT_W'(MIN_CYC - 1));
  wire armed = (cnt_ff != '0) && (cnt_ff < CNT_W'(MIN_CYC));

  assign nxt_cnt = !differs ? '0 : (cnt_ff == CNT_W'(MIN_CYC)) ? cnt_ff : cnt_ff + 1'b1;
  assign change_o = differs && reached;
  assign short_o = watch_i && !differs && armed;
  assign level_o = sync_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      ref_ff <= watch_i ? ref_ff : sync_ff;
      cnt_ff <= nxt_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pin_gated: assert property (change_o |-> watch_i && $past(watch_i))
    else $error("wake change reported on an unwatched pin");
  a_width_met: assert property (change_o |-> $past(differs))
    else $error("wake change reported before minimum width");

endmodule // wake_pin_watch

// >>> test/wake_far_side.sv
// Far-side model: watchdog time-out, port pins, external reset pin and debug pin.
// Assumes the bench calls its tasks just after a rising edge of clk_i, DLY after it.
module wake_far_side #(
  parameter int PINS = 8,
  parameter int DLY = 2
) (
  input wire logic clk_i,
  output logic wdt_timeout_o,
  output logic [PINS-1:0] pin_o,
  output logic ext_reset_n_o,
  output logic debug_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------------
  // Idle levels: reset and debug pins rest high through their pull-ups
  // --------------------------------------------------------------------------
  initial begin
    wdt_timeout_o = 1'b0;
    pin_o = '0;
    ext_reset_n_o = 1'b1;
    debug_pin_o = 1'b1;
  end

  // --------------------------------------------------------------------------
  // Stimulus tasks
  // --------------------------------------------------------------------------
  task automatic fire_wdt();
    wdt_timeout_o = 1'b1;
    @(posedge clk_i);
    #DLY;
    wdt_timeout_o = 1'b0;
  endtask

  task automatic set_pins(input logic [PINS-1:0] v);
    pin_o = v;
  endtask

  task automatic pulse_pin(input int idx, input int cyc);
    pin_o[idx] = ~pin_o[idx];
    repeat (cyc) @(posedge clk_i);
    #DLY;
    pin_o[idx] = ~pin_o[idx];
  endtask

  task automatic pull_low(input logic dbg, input int cyc);
    if (dbg) begin
      debug_pin_o = 1'b0;
    end else begin
      ext_reset_n_o = 1'b0;
    end
    repeat (cyc) @(posedge clk_i);
    #DLY;
    debug_pin_o = 1'b1;
    ext_reset_n_o = 1'b1;
  endtask
endmodule // wake_far_side

// >>> test/stop_mode_wake_control_tb.sv
// Self-checking bench for the halted-state wake sequencer.
// Assumes wake_far_side drives the pins; short counts are set by parameter.
module stop_mode_wake_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wake_ctl_pkg::*;

  localparam int DLY = 2;
  localparam int REC = 4;
  localparam int MINC = 2;
  localparam int LIMIT = 20000;

  logic ref_clk, reset_n, halt_req, wdt_mode, irq_en, cause_clr;
  logic [7:0] wake_en, pins_old;
  logic wdt_to, ext_n, dbg;
  logic [7:0] pins;
  logic halted, cpu_en, fetch, sys_rst, irq, cap_en;
  logic [7:0] port_data, cause;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int cyc, en, dis;
  logic early;

  stop_mode_wake_control #(.PINS(8), .WAKE_MIN_CYC(MINC), .RECOVERY_CYC(REC))
    stop_mode_wake_control_i (
    .REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .HALT_REQ_I(halt_req),
    .WDT_TIMEOUT_I(wdt_to), .WDT_RESET_MODE_I(wdt_mode), .IRQ_GLOBAL_EN_I(irq_en),
    .WAKE_EN_I(wake_en), .PORT_PIN_I(pins), .EXT_RESET_N_I(ext_n), .DEBUG_PIN_I(dbg),
    .CAUSE_CLEAR_I(cause_clr), .HALTED_O(halted), .CPU_CLK_EN_O(cpu_en),
    .FETCH_RESUME_O(fetch), .SYS_RESET_O(sys_rst), .WDT_IRQ_O(irq),
    .PORT_CAPTURE_EN_O(cap_en), .PORT_INPUT_DATA_O(port_data), .RESET_CAUSE_O(cause));

  wake_far_side #(.PINS(8), .DLY(DLY)) wake_far_side_i (
    .clk_i(ref_clk), .wdt_timeout_o(wdt_to), .pin_o(pins),
    .ext_reset_n_o(ext_n), .debug_pin_o(dbg));

  // --------------------------------------------------------------------------
  // Clock, cycle limit and shared tasks
  // --------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #DLY;
  endtask

  // Counts edges from now until a resume or system reset pulse shows
  task automatic wait_pulse(output int c, output logic irq_early);
    c = 0;
    irq_early = 1'b0;
    while (fetch !== 1'b1 && sys_rst !== 1'b1 && c < 60) begin
      if (irq === 1'b1) begin
        irq_early = 1'b1;
      end
      step(1);
      c++;
    end
  endtask

  // Halt, external, watchdog and debug flags sit in the top nibble
  function automatic logic [7:0] cause_of(input logic halt, ext, wdog, dbg);
    return {halt, ext, wdog, dbg, 4'h0};
  endfunction

  function automatic logic irq_of(input logic reset_mode, gie);
    return !reset_mode && gie;
  endfunction

  task automatic halt_enter();
    cause_clr = 1'b1;
    step(1);
    cause_clr = 1'b0;
    halt_req = 1'b1;
    step(1);
    halt_req = 1'b0;
    check(halted, 1'b1);
    check({cpu_en, cap_en}, 2'b00);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(32'hf7fff7d9));
    {reset_n, halt_req, wdt_mode, irq_en, cause_clr} = 5'h00;
    wake_en = 8'h00;
    repeat (20) @(posedge ref_clk);
    #DLY;
    reset_n = 1'b1;
    wake_far_side_i.set_pins(8'($urandom));
    step(4);
    check(cause, 8'h00);
    check({cpu_en, cap_en}, 2'b11);
    for (int m = 0; m < 4; m++) begin
      {irq_en, wdt_mode} = 2'(m);
      halt_enter();
      fork
        wake_far_side_i.fire_wdt();
        wait_pulse(cyc, early);
        begin
          // Last pass clears the causes in the very cycle the watchdog sets them
          cause_clr = (m == 3);
          step(1);
          cause_clr = 1'b0;
        end
      join
      check(cyc, REC + 1);
      check({fetch, sys_rst}, 2'b10);
      check(irq, irq_of(wdt_mode, irq_en));
      check(early, 1'b0);
      check(cause, cause_of(1'b1, 1'b0, 1'b1, 1'b0));
      step(2);
    end
    for (int r = 0; r < 8; r++) begin
      en = $urandom % 8;
      dis = (en + 1 + $urandom % 7) % 8;
      wake_en = (8'($urandom) & ~(8'h01 << dis)) | (8'h01 << en);
      pins_old = pins;
      check(port_data, pins_old);
      halt_enter();
      wake_far_side_i.set_pins(pins ^ (8'h01 << dis));
      step(8);
      check(halted, 1'b1);
      check(port_data, pins_old);
      if (r % 2 == 1) begin
        wake_far_side_i.pulse_pin(en, 1);
        step(6);
        check(halted, 1'b1);
        check(cause, cause_of(1'b1, 1'b0, 1'b0, 1'b0));
      end
      wake_far_side_i.set_pins(pins ^ (8'h01 << en));
      wait_pulse(cyc, early);
      check({fetch, sys_rst}, 2'b10);
      check(port_data, pins);
      check(cause, cause_of(1'b1, 1'b0, 1'b0, 1'b0));
      step(3);
    end
    for (int d = 0; d < 2; d++) begin
      halt_enter();
      fork
        wake_far_side_i.pull_low(d[0], 6);
        begin
          wait_pulse(cyc, early);
          check({fetch, sys_rst}, 2'b01);
        end
      join
      check(cause, cause_of(1'b0, !d[0], 1'b0, d[0]));
      step(4);
    end
    // Reset dropped in mid-recovery must return every output to its idle value
    halt_enter();
    wake_far_side_i.fire_wdt();
    step(1);
    reset_n = 1'b0;
    #1;
    check({halted, cpu_en, cap_en, fetch, sys_rst, irq}, 6'b011000);
    check(cause, 8'h00);
    check(port_data, 8'h00);
    step(2);
    reset_n = 1'b1;
    step(4);
    check({halted, cpu_en, cap_en}, 3'b011);
    check(port_data, pins);
    wrap_up();
  end
endmodule // stop_mode_wake_control_tb
